// ==== rtl/rso_reset_status_and_options.sv ====
// Reset cause flags, debug forced reset and write-once options
`timescale 1ns/1ns
`default_nettype none

// How it works
// RULE1 - Reset cause flags are read-only and record what caused the last reset.
// RULE2 - A debug forced reset sets no reset cause flag.
// RULE3 - Any write to the cause address restarts the watchdog, flags unchanged.
// RULE4 - Power-on reset sets bit 7 and bit 1, all others zero.
// RULE5 - Low-voltage reset keeps bit 7, sets bit 1, clears the rest.
// RULE6 - Other resets set active source flags; bits 7,3,1,0 read zero.
// RULE7 - Bit 6 marks a reset from the external reset pin.
// RULE8 - Bit 5 marks watchdog timeout; blocked when watchdog enable is zero.
// RULE9 - Bit 4 marks illegal opcode, including disabled halt or background.
// RULE10 - Bit 2 marks a reset requested by the clock generator.
// RULE11 - Bit 1 low-voltage reset needs both enables; halt blocks without halt enable.
// RULE12 - Force-reset register takes debug writes only and always reads zero.
// RULE13 - Debug write of one to force-reset bit resets the whole device.
// RULE14 - Options register readable anytime; bits 3 and 2 read zero.
// RULE15 - Options register takes only the first write after each reset.
// RULE16 - Software should write options once during reset initialisation.
// RULE17 - Options bit 7 watchdog enable resets to one.
// RULE18 - Options bit 6 resets to one; long or short watchdog period.
// RULE19 - Options bit 5 halt enable resets to zero; halt otherwise illegal.
// RULE20 - Options bit 1 selects debug pin function; defaults to debug.
// RULE21 - Internal lock flag cleared by reset, set by first accepted write.
module rso_reset_status_and_options (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic dbg_wr,
    input wire logic [1:0] dbg_addr,
    input wire logic [7:0] dbg_wdata,
    input wire rso_pkg::rso_src_t src,
    input wire rso_pkg::rso_gate_t gate,
    output logic reset_request,
    output logic wdog_restart,
    output logic watchdog_enable,
    output logic watchdog_long_period,
    output logic [18:0] wdog_period_cycles,
    output logic halt_mode_enable,
    output logic debug_pin_enable,
    output logic options_locked
);

    // Address match helper
    function automatic logic hit(
        input logic [1:0] addr,
        input logic [1:0] target
    );
        hit = (addr == target);
    endfunction

    logic [7:0] reset_cause_r;
    logic [7:0] system_options_r;
    logic lock_r;
    logic [7:0] rdata_r;
    logic reset_req_r;
    logic restart_r;
    logic rst_d_r;
    // Pending causes, held from the request until reset is released
    logic pend_pin_r;
    logic pend_wdog_r;
    logic pend_illegal_opcode_flag_r;
    logic pend_clkgen_r;
    logic pend_lv_r;

    logic wdog_req;
    logic illegal_opcode_flag_req;
    logic lv_req;
    logic force_req;
    logic user_opt_wr;
    logic dbg_opt_wr;
    logic cause_wr;
    logic [7:0] opt_wdata;
    logic [7:0] cause_nxt;

    // Gated reset sources
    assign wdog_req = src.wdog_timeout
        & system_options_r[rso_pkg::OPT_WDOG_EN]; // RULE8 RULE17
    assign illegal_opcode_flag_req = src.illegal_opcode
        | (src.halt_exec & ~system_options_r[rso_pkg::OPT_HALT_EN]) // RULE19
        | (src.background_instruction_exec & ~gate.background_mode_enable); // RULE9
    assign lv_req = src.low_voltage
        & gate.low_voltage_detect_enable
        & gate.low_voltage_reset_enable
        & (~gate.in_halt | gate.low_voltage_halt_enable); // RULE11

    // Debug-only force reset; user bus writes never reach it
    assign force_req = dbg_wr
        & hit(dbg_addr, rso_pkg::ADDR_FORCE)
        & dbg_wdata[rso_pkg::FORCE_BIT]; // RULE12 RULE13

    // Write decode; the user bus wins a same-cycle clash
    assign user_opt_wr = bus_wr & hit(bus_addr, rso_pkg::ADDR_OPTS);
    assign dbg_opt_wr = dbg_wr & hit(dbg_addr, rso_pkg::ADDR_OPTS);
    assign opt_wdata = user_opt_wr ? bus_wdata : dbg_wdata;
    assign cause_wr = (bus_wr & hit(bus_addr, rso_pkg::ADDR_CAUSE))
        | (dbg_wr & hit(dbg_addr, rso_pkg::ADDR_CAUSE));

    // Cause value loaded on every reset cycle
    always_comb
    begin
        cause_nxt = rso_pkg::CAUSE_RESET;
        if (src.por_level)
        begin
            cause_nxt = rso_pkg::CAUSE_POWER_ON; // RULE4
        end
        else if (pend_lv_r)
        begin
            cause_nxt[rso_pkg::CAUSE_POR] =
                reset_cause_r[rso_pkg::CAUSE_POR]; // RULE5
            cause_nxt[rso_pkg::CAUSE_LV] = 1'b1; // RULE5
        end
        else
        begin
            // Forced debug reset has no pending flag of its own
            cause_nxt[rso_pkg::CAUSE_PIN] = src.pin_level
                | pend_pin_r; // RULE7 RULE6 RULE2
            cause_nxt[rso_pkg::CAUSE_WDOG] = pend_wdog_r; // RULE8 RULE6
            cause_nxt[rso_pkg::CAUSE_ILLEGAL_OPCODE_FLAG] = pend_illegal_opcode_flag_r; // RULE9 RULE6
            cause_nxt[rso_pkg::CAUSE_CLKGEN] = pend_clkgen_r; // RULE10
        end
    end

    // Reset release edge tracking
    always_ff @(posedge core_clk)
    begin
        rst_d_r <= rst;
    end

    // Pending causes: held through reset, cleared after release
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pend_pin_r <= pend_pin_r | src.pin_level;
            pend_wdog_r <= pend_wdog_r;
            pend_illegal_opcode_flag_r <= pend_illegal_opcode_flag_r;
            pend_clkgen_r <= pend_clkgen_r;
            pend_lv_r <= pend_lv_r | lv_req;
        end
        else if (rst_d_r)
        begin
            // New events in the release cycle win over the clear
            pend_pin_r <= src.pin_level;
            pend_wdog_r <= wdog_req;
            pend_illegal_opcode_flag_r <= illegal_opcode_flag_req;
            pend_clkgen_r <= src.clkgen_req;
            pend_lv_r <= lv_req;
        end
        else
        begin
            pend_pin_r <= pend_pin_r | src.pin_level;
            pend_wdog_r <= pend_wdog_r | wdog_req;
            pend_illegal_opcode_flag_r <= pend_illegal_opcode_flag_r | illegal_opcode_flag_req;
            pend_clkgen_r <= pend_clkgen_r | src.clkgen_req;
            pend_lv_r <= pend_lv_r | lv_req;
        end
    end

    // Reset cause register: loaded only while reset is active
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            reset_cause_r <= cause_nxt; // RULE1 RULE6
        end
        else
        begin
            reset_cause_r <= reset_cause_r; // RULE1 RULE3
        end
    end

    // Reset request toward the reset controller
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            reset_req_r <= 1'b0;
        end
        else
        begin
            reset_req_r <= wdog_req | illegal_opcode_flag_req | lv_req
                | src.clkgen_req | force_req; // RULE13
        end
    end

    // Watchdog restart pulse on any cause-address write
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            restart_r <= 1'b0;
        end
        else
        begin
            restart_r <= cause_wr; // RULE3
        end
    end

    // Write-once options register and its lock
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            system_options_r <= rso_pkg::OPT_RESET; // RULE17 RULE18 RULE19
            lock_r <= 1'b0; // RULE21
        end
        else if ((user_opt_wr | dbg_opt_wr) & ~lock_r)
        begin
            system_options_r <= opt_wdata & rso_pkg::OPT_MASK; // RULE14
            lock_r <= 1'b1; // RULE15 RULE21
        end
        else
        begin
            system_options_r <= system_options_r; // RULE15
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rdata_r <= rso_pkg::READ_ZERO;
        end
        else if (bus_rd)
        begin
            case (bus_addr)
                rso_pkg::ADDR_CAUSE: rdata_r <= reset_cause_r; // RULE1
                rso_pkg::ADDR_FORCE: rdata_r <= rso_pkg::FORCE_READ; // RULE12
                rso_pkg::ADDR_OPTS: rdata_r <= system_options_r; // RULE14
                default: rdata_r <= rso_pkg::READ_ZERO;
            endcase
        end
        else
        begin
            rdata_r <= rdata_r;
        end
    end

    // Outputs
    assign bus_rdata = rdata_r;
    assign reset_request = reset_req_r;
    assign wdog_restart = restart_r;
    assign watchdog_enable = system_options_r[rso_pkg::OPT_WDOG_EN]; // RULE17
    assign watchdog_long_period =
        system_options_r[rso_pkg::OPT_WDOG_LONG]; // RULE18
    assign wdog_period_cycles =
        system_options_r[rso_pkg::OPT_WDOG_LONG]
        ? rso_pkg::WDOG_LONG_CYC : rso_pkg::WDOG_SHORT_CYC; // RULE18
    assign halt_mode_enable = system_options_r[rso_pkg::OPT_HALT_EN];
    assign debug_pin_enable = system_options_r[rso_pkg::OPT_DBG_PIN]; // RULE20
    assign options_locked = lock_r;

endmodule

`default_nettype wire

// ==== pkg/rso_pkg.sv ====
// Constants and carrier types for the reset status and options bank
package rso_pkg;
    // Register addresses on the internal bus
    localparam logic [1:0] ADDR_CAUSE = 2'h0;
    localparam logic [1:0] ADDR_FORCE = 2'h1;
    localparam logic [1:0] ADDR_OPTS = 2'h2;
    // Reset cause field positions
    localparam int CAUSE_POR = 7;
    localparam int CAUSE_PIN = 6;
    localparam int CAUSE_WDOG = 5;
    localparam int CAUSE_ILLEGAL_OPCODE_FLAG = 4;
    localparam int CAUSE_CLKGEN = 2;
    localparam int CAUSE_LV = 1;
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    localparam logic [7:0] CAUSE_POWER_ON = 8'h82;
    // Force-reset bit position and read value
    localparam int FORCE_BIT = 0;
    localparam logic [7:0] FORCE_READ = 8'h00;
    // Options field positions, implemented mask and reset value
    localparam int OPT_WDOG_EN = 7;
    localparam int OPT_WDOG_LONG = 6;
    localparam int OPT_HALT_EN = 5;
    localparam int OPT_DBG_PIN = 1;
    localparam logic [7:0] OPT_MASK = 8'hF3;
    localparam logic [7:0] OPT_RESET = 8'hC2;
    // Watchdog periods in bus clock cycles
    localparam logic [18:0] WDOG_SHORT_CYC = 19'h0_2000;
    localparam logic [18:0] WDOG_LONG_CYC = 19'h4_0000;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Raw reset sources and execution events from the core
    typedef struct packed {
        logic por_level;
        logic pin_level;
        logic wdog_timeout;
        logic illegal_opcode;
        logic halt_exec;
        logic background_instruction_exec;
        logic clkgen_req;
        logic low_voltage;
    } rso_src_t;

    // Enables that gate some sources
    typedef struct packed {
        logic low_voltage_detect_enable;
        logic low_voltage_reset_enable;
        logic low_voltage_halt_enable;
        logic in_halt;
        logic background_mode_enable;
    } rso_gate_t;
endpackage

// ==== sim/rso_checker_props.sv ====
// Checker for the reset status and options bank
`timescale 1ns/1ns
`default_nettype none
module rso_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [7:0] bus_wdata,
    input wire logic dbg_wr,
    input wire logic [1:0] dbg_addr,
    input wire logic [7:0] dbg_wdata,
    input wire rso_pkg::rso_src_t src,
    input wire logic reset_request,
    input wire logic wdog_restart,
    input wire logic watchdog_enable,
    input wire logic watchdog_long_period,
    input wire logic [18:0] wdog_period_cycles,
    input wire logic halt_mode_enable,
    input wire logic debug_pin_enable,
    input wire logic options_locked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // First accepted user-bus options write and any cause-address write
    sequence s_first_wr;
        bus_wr && bus_addr == 2'h2 && !options_locked;
    endsequence
    sequence s_cause_wr;
        (bus_wr && bus_addr == 2'h0) || (dbg_wr && dbg_addr == 2'h0);
    endsequence
    opt_reset_a: assert property ($fell(rst) |-> watchdog_enable
        && watchdog_long_period && !halt_mode_enable && debug_pin_enable
        && !options_locked) else $error("options not at reset values");
    wdog_restart_a: assert property (s_cause_wr |=> wdog_restart)
        else $error("no watchdog restart after cause write");
    force_req_a: assert property (dbg_wr && dbg_addr == 2'h1
        && dbg_wdata[0] |=> reset_request) else $error("no forced reset");
    user_force_a: assert property (bus_wr && bus_addr == 2'h1
        && src == '0 && !dbg_wr && !reset_request |=> !reset_request)
        else $error("user write forced a reset");
    lock_set_a: assert property (s_first_wr |=> options_locked
        && watchdog_enable == $past(bus_wdata[7])
        && halt_mode_enable == $past(bus_wdata[5]))
        else $error("first options write not taken");
    lock_hold_a: assert property (options_locked |=> $stable({
        watchdog_enable, watchdog_long_period, halt_mode_enable,
        debug_pin_enable})) else $error("locked options changed");
    period_sel_a: assert property (wdog_period_cycles ==
        (watchdog_long_period ? 19'h4_0000 : 19'h0_2000))
        else $error("wrong watchdog period");
    opt_read_a: assert property (bus_rd && bus_addr == 2'h2
        |=> bus_rdata[3:2] == 2'h0) else $error("options bits 3:2 set");
    force_read_a: assert property (bus_rd && bus_addr == 2'h1
        |=> bus_rdata == 8'h00) else $error("force register read nonzero");
    halt_illegal_opcode_flag_a: assert property (!halt_mode_enable && src.halt_exec
        |=> reset_request) else $error("illegal halt gave no reset");
endmodule
bind rso_reset_status_and_options rso_checker i_chk (.core_clk, .rst,
    .bus_addr, .bus_wr, .bus_rd, .bus_rdata, .bus_wdata, .dbg_wr,
    .dbg_addr, .dbg_wdata, .src, .reset_request, .wdog_restart,
    .watchdog_enable, .watchdog_long_period, .wdog_period_cycles,
    .halt_mode_enable, .debug_pin_enable, .options_locked);
`default_nettype wire

// ==== sim/rso_dbg_host.sv ====
// Serial debug host model issuing decoded write commands
`timescale 1ns/1ns
`default_nettype none
module rso_dbg_host (
    input wire logic core_clk,
    output logic dbg_wr,
    output logic [1:0] dbg_addr,
    output logic [7:0] dbg_wdata
);
    initial
    begin
        dbg_wr = 1'h0;
        dbg_addr = 2'h3;
        dbg_wdata = 8'h00;
    end
    // One debug write; idle lines then show inverted stale values
    task automatic put(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        dbg_wr <= 1'h1;
        dbg_addr <= a;
        dbg_wdata <= v;
        @(posedge core_clk);
        dbg_wr <= 1'h0;
        dbg_addr <= ~a;
        dbg_wdata <= ~v;
    endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the reset status and options bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [1:0] bus_addr = 2'h0;
    logic bus_wr = 1'h0;
    logic bus_rd = 1'h0;
    logic [7:0] bus_wdata = 8'h00;
    rso_pkg::rso_src_t src = 8'h80;
    rso_pkg::rso_gate_t gate = 5'h18;
    wire logic [7:0] bus_rdata;
    wire logic dbg_wr;
    wire logic [1:0] dbg_addr;
    wire logic [7:0] dbg_wdata;
    wire logic reset_request;
    wire logic wdog_restart;
    int n_errors = 0;
    int checked = 0;
    logic [7:0] d;
    rso_reset_status_and_options i_dut (.core_clk, .rst, .bus_addr,
        .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .dbg_wr, .dbg_addr,
        .dbg_wdata, .src, .gate, .reset_request, .wdog_restart,
        .watchdog_enable(), .watchdog_long_period(),
        .wdog_period_cycles(), .halt_mode_enable(), .debug_pin_enable(),
        .options_locked());
    rso_dbg_host i_host (.core_clk, .dbg_wr, .dbg_addr, .dbg_wdata);
    // Clock at 10 MHz
    always #50 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        bus_rd <= 1'h1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd <= 1'h0;
        #1 v = bus_rdata;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        bus_wr <= 1'h1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge core_clk);
        bus_wr <= 1'h0;
        #1;
    endtask
    task automatic reset_dut(input int n);
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (n) @(posedge core_clk);
        rst <= 1'h0;
        src <= '0;
    endtask
    // Source held into reset; flag byte read back afterwards
    task automatic t_src(input logic [7:0] s, input logic [7:0] e);
        @(posedge core_clk);
        src <= s;
        @(posedge core_clk);
        #1 chk({7'h0, reset_request}, {7'h0, |s[5:0]});
        reset_dut(2);
        rd(2'h0, d);
        chk(d, e);
    endtask
    task automatic t_force;
        wr(2'h1, 8'h01);
        chk({7'h0, reset_request}, 8'h00);
        rd(2'h1, d);
        chk(d, 8'h00);
        i_host.put(2'h1, 8'h01);
        #1 chk({7'h0, reset_request}, 8'h01);
        reset_dut(2);
        rd(2'h0, d);
        chk(d, 8'h00);
    endtask
    task automatic t_opts;
        wr(2'h2, 8'h00);
        rd(2'h2, d);
        chk(d, 8'h00);
        wr(2'h2, 8'hFF);
        rd(2'h2, d);
        chk(d, 8'h00);
        rd(2'h3, d);
        chk(d, 8'h00);
    endtask
    // Gated source held two cycles; request expected or blocked
    task automatic t_req(input logic [7:0] s, input logic [4:0] g,
        input logic e);
        @(posedge core_clk);
        src <= s;
        gate <= g;
        @(posedge core_clk);
        #1 chk({7'h0, reset_request}, {7'h0, e});
        @(posedge core_clk);
        src <= '0;
        gate <= 5'h18;
        @(posedge core_clk);
    endtask
    task automatic stop_test;
        $display("n_errors=%0d checked=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog against hangs
    initial
    begin
        #100000;
        n_errors++;
        stop_test();
    end
    // Main sequence
    initial
    begin
        reset_dut(8);
        rd(2'h2, d);
        chk(d, 8'hC2);
        rd(2'h0, d);
        chk(d, 8'h82);
        wr(2'h0, 8'hFF);
        chk({7'h0, wdog_restart}, 8'h01);
        i_host.put(2'h0, 8'h55);
        #1 chk({7'h0, wdog_restart}, 8'h01);
        rd(2'h0, d);
        chk(d, 8'h82);
        t_force();
        t_src(8'h40, 8'h40);
        t_src(8'h20, 8'h20);
        t_src(8'h10, 8'h10);
        t_src(8'h08, 8'h10);
        t_src(8'h04, 8'h10);
        t_src(8'h02, 8'h04);
        t_src(8'h01, 8'h02);
        t_src(8'h60, 8'h60);
        t_opts();
        t_req(8'h20, 5'h18, 1'h0);
        t_req(8'h01, 5'h1A, 1'h0);
        t_req(8'h01, 5'h1E, 1'h1);
        t_req(8'h04, 5'h19, 1'h0);
        reset_dut(2);
        wr(2'h2, 8'hFF);
        rd(2'h2, d);
        chk(d, 8'hF3);
        rd(2'h0, d);
        chk(d, 8'h02);
        stop_test();
    end
endmodule
`default_nettype wire
